//--- pkg/pscap_consts.svh
`ifndef PSCAP_CONSTS_SVH
`define PSCAP_CONSTS_SVH

// ****************************************
// clock and drive timing
// ****************************************
`define PSCAP_CLK_HZ 100000000
`define PSCAP_DRIVE_HZ 115000
`define PSCAP_PERIOD_CYC ((`PSCAP_CLK_HZ + `PSCAP_DRIVE_HZ / 2) / `PSCAP_DRIVE_HZ)
`define PSCAP_HALF_CYC (`PSCAP_PERIOD_CYC / 2)

// ****************************************
// phase, in hundredths of a degree
// ****************************************
`define PSCAP_PHASE_MAX_CDEG 18000
`define PSCAP_PING_PHASE_CDEG 15000
`define PSCAP_FULL_TURN_CDEG 36000
`define PSCAP_LIMIT_STEP_CDEG 100

// ****************************************
// control loop
// ****************************************
`define PSCAP_PROPORTIONAL_GAIN 1
`define PSCAP_LOOP_OUTPUT_LIMIT 2000

// ****************************************
// current limits, mA
// ****************************************
`define PSCAP_LIMIT_PAIR_RMS_MA 4000
`define PSCAP_LIMIT_SINGLE_RMS_MA 3000
`define PSCAP_SQRT2_MILLI 1414

// ****************************************
// coil array
// ****************************************
`define PSCAP_COIL_COUNT 8
`define PSCAP_COIL_LAST 7

`endif

//--- pkg/pscap_pkg.sv
package pscap_pkg;

  typedef enum logic [2:0] {
    PSCAP_IDLE  = 3'b001,
    PSCAP_PING  = 3'b010,
    PSCAP_POWER = 3'b100
  } pscap_state_e;

  typedef logic [15:0] pscap_ma_t;
  typedef logic [14:0] pscap_cdeg_t;
  typedef logic [2:0] pscap_coil_t;
  typedef logic [7:0] pscap_mask_t;

endpackage

//--- rtl/pscap_ctrl.sv
`timescale 1ns/1ps
`include "pscap_consts.svh"

module pscap_ctrl (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic drive_enable,
  input wire logic ping_start,
  input wire logic position_valid,
  input wire pscap_pkg::pscap_coil_t position_coil,
  input wire logic position_pair,
  input wire logic loop_update,
  input wire pscap_pkg::pscap_ma_t target_current_ma,
  input wire logic current_valid,
  input wire pscap_pkg::pscap_ma_t cell_current_ma,
  output pscap_pkg::pscap_mask_t coil_enable,
  output logic parallel_switch,
  output logic leg_a,
  output logic leg_b,
  output pscap_pkg::pscap_cdeg_t phase_cdeg,
  output logic current_limit_active,
  output pscap_pkg::pscap_state_e ctrl_state
);
  import pscap_pkg::*;

  // ****************************************
  // state machine
  // ****************************************
  pscap_state_e state_q;
  pscap_state_e state_d;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PSCAP_IDLE: begin
        if (drive_enable && ping_start) begin
          state_d = PSCAP_PING;
        end
      end
      PSCAP_PING: begin
        if (!drive_enable) begin
          state_d = PSCAP_IDLE;
        end else if (loop_update) begin
          state_d = PSCAP_POWER;
        end
      end
      PSCAP_POWER: begin
        if (!drive_enable) begin
          state_d = PSCAP_IDLE;
        end else if (ping_start) begin
          state_d = PSCAP_PING;
        end
      end
      default: begin
        state_d = PSCAP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= PSCAP_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  wire logic running = (state_q != PSCAP_IDLE);

  // ****************************************
  // coil selection
  // ****************************************
  // the mux only moves while the bridge is idle; switching coils under
  // load would interrupt cell current through the matching network
  wire logic sel_take = position_valid && (state_q == PSCAP_IDLE);
  // a pair is the chosen coil and its neighbour in the other layer,
  // which overlap by about half; the last coil has no neighbour
  wire logic pair_ok = position_pair && (position_coil != 3'(`PSCAP_COIL_LAST));
  wire pscap_mask_t first_bit = 8'h01 << position_coil;
  wire pscap_mask_t second_bit = pair_ok ? (first_bit << 1) : 8'h00;
  wire pscap_mask_t sel_mask = first_bit | second_bit;

  pscap_mask_t coil_q;
  logic pair_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      coil_q <= 8'h01;
      pair_q <= 1'b0;
    end else if (sel_take) begin
      coil_q <= sel_mask;
      pair_q <= pair_ok;
    end
  end

  assign coil_enable = coil_q;
  assign parallel_switch = pair_q;

  // ****************************************
  // current measurement and limit
  // ****************************************
  localparam int LimPairPk = `PSCAP_LIMIT_PAIR_RMS_MA * `PSCAP_SQRT2_MILLI / 1000;
  localparam int LimSinglePk = `PSCAP_LIMIT_SINGLE_RMS_MA * `PSCAP_SQRT2_MILLI / 1000;

  pscap_ma_t cur_q;
  logic limit_q;

  // measurement is an amplitude, so the rms cap is scaled to peak
  wire pscap_ma_t limit_pk = pair_q ? 16'(LimPairPk) : 16'(LimSinglePk);
  wire logic over_limit = current_valid && (cell_current_ma > limit_pk);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cur_q <= 16'h0000;
      limit_q <= 1'b0;
    end else if (!running) begin
      limit_q <= 1'b0;
    end else if (current_valid) begin
      cur_q <= cell_current_ma;
      limit_q <= over_limit;
    end
  end

  assign current_limit_active = limit_q;

  // ****************************************
  // proportional loop
  // ****************************************
  // integral and derivative gains are zero, so only the p term is built
  localparam int OutLim = `PSCAP_LOOP_OUTPUT_LIMIT;

  pscap_cdeg_t phase_q;
  pscap_cdeg_t phase_d;

  // limits held as signed nets: an unsigned operand would turn the
  // compares unsigned and clamp every negative error to the top
  wire logic signed [17:0] out_lim = 18'(OutLim);
  wire logic signed [17:0] gain_s = 18'(`PSCAP_PROPORTIONAL_GAIN);
  wire logic signed [17:0] phase_max_s = 18'(`PSCAP_PHASE_MAX_CDEG);

  wire logic signed [17:0] err = $signed({2'b00, target_current_ma})
    - $signed({2'b00, cur_q});
  wire logic signed [17:0] p_term = err * gain_s;
  wire logic signed [17:0] pid_out = (p_term > out_lim) ? out_lim
    : (p_term < -out_lim) ? -out_lim : p_term;

  // phase is held in 0.01 degree units, so the 0.01 scale is one lsb;
  // more current than wanted raises the phase and lowers power
  wire logic signed [17:0] loop_new = $signed({3'b000, phase_q}) - pid_out;
  wire pscap_cdeg_t loop_clamped = (loop_new < 18'sd0) ? 15'h0000
    : (loop_new > phase_max_s) ? 15'(`PSCAP_PHASE_MAX_CDEG)
    : loop_new[14:0];

  // while capped, the loop may not lower the phase again
  wire logic loop_blocked = limit_q && (loop_clamped < phase_q);

  wire logic [15:0] step_sum = {1'b0, phase_q} + 16'(`PSCAP_LIMIT_STEP_CDEG);
  wire pscap_cdeg_t step_clamped = (step_sum > 16'(`PSCAP_PHASE_MAX_CDEG))
    ? 15'(`PSCAP_PHASE_MAX_CDEG) : step_sum[14:0];

  // ****************************************
  // phase register
  // ****************************************
  always_comb begin
    phase_d = phase_q;
    if (!running) begin
      phase_d = 15'(`PSCAP_PING_PHASE_CDEG);
    end else if (ping_start) begin
      phase_d = 15'(`PSCAP_PING_PHASE_CDEG);
    end else if (over_limit) begin
      phase_d = step_clamped;
    end else if (loop_update && !loop_blocked) begin
      phase_d = loop_clamped;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 15'(`PSCAP_PING_PHASE_CDEG);
    end else begin
      phase_q <= phase_d;
    end
  end

  assign phase_cdeg = phase_q;

  // ****************************************
  // bridge drive
  // ****************************************
  // one clock is 360/870 degree, below the 1 degree limit step
  localparam int PeriodCyc = `PSCAP_PERIOD_CYC;
  localparam int HalfCyc = `PSCAP_HALF_CYC;

  logic [9:0] cnt_q;
  logic [9:0] shift_q;
  logic leg_a_q;
  logic leg_b_q;

  wire logic period_end = (cnt_q == 10'(PeriodCyc - 1));
  wire logic [31:0] shift_wide = 32'(phase_q) * 32'(PeriodCyc)
    / 32'(`PSCAP_FULL_TURN_CDEG);
  wire logic [10:0] b_pos_raw = {1'b0, cnt_q} + 11'(PeriodCyc) - {1'b0, shift_q};
  wire logic [10:0] b_pos = (b_pos_raw >= 11'(PeriodCyc))
    ? b_pos_raw - 11'(PeriodCyc) : b_pos_raw;
  // leg b is the complement of a delayed copy of leg a: zero shift
  // gives full bridge voltage, a half period gives none
  wire logic leg_a_d = running && (cnt_q < 10'(HalfCyc));
  wire logic leg_b_d = running && (b_pos >= 11'(HalfCyc));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 10'h000;
    end else if (!running || period_end) begin
      cnt_q <= 10'h000;
    end else begin
      cnt_q <= cnt_q + 10'h001;
    end
  end

  // shift only moves at a period boundary or while idle, so no pulse is cut short
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= 10'h000;
    end else if (!running || period_end) begin
      shift_q <= shift_wide[9:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      leg_a_q <= 1'b0;
      leg_b_q <= 1'b0;
    end else begin
      leg_a_q <= leg_a_d;
      leg_b_q <= leg_b_d;
    end
  end

  assign leg_a = leg_a_q;
  assign leg_b = leg_b_q;
  assign ctrl_state = state_q;

endmodule

//--- testbench/phase_shift_coil_array_power_control_tb.sv
`timescale 1ns/1ps
module phase_shift_coil_array_power_control_tb;
  import pscap_pkg::*;
  typedef struct {logic [2:0] c; logic p; logic [7:0] m;} pscap_row_s;
  logic clock, rst_n, drive_enable, ping_start, position_valid, position_pair, loop_update;
  logic current_valid, parallel_switch, leg_a, leg_b, current_limit_active;
  pscap_coil_t position_coil;
  pscap_ma_t target_current_ma, cell_current_ma, amp_ma;
  pscap_mask_t coil_enable;
  pscap_cdeg_t phase_cdeg, ph;
  pscap_state_e ctrl_state;
  int n_mismatch = 0;
  int compares = 0;
  int n_cyc;
  pscap_row_s rows[5] = '{'{3'h2, 1'h1, 8'h0C}, '{3'h0, 1'h0, 8'h01}, '{3'h7, 1'h1, 8'h80},
    '{3'h5, 1'h0, 8'h20}, '{3'h6, 1'h1, 8'hC0}};
  pscap_ctrl dut_u (.clock, .rst_n, .drive_enable, .ping_start, .position_valid, .position_coil,
    .position_pair, .loop_update, .target_current_ma, .current_valid, .cell_current_ma,
    .coil_enable, .parallel_switch, .leg_a, .leg_b, .phase_cdeg, .current_limit_active, .ctrl_state);
  pscap_sense sense_u (.clock, .rst_n, .leg_a, .amp_ma, .current_valid, .cell_current_ma);
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
  endtask
  task automatic upd(logic [15:0] t, logic [15:0] e);
    target_current_ma = t;
    pulse(loop_update);
    chk("phase", e, phase_cdeg);
    ph = e;
  endtask
  task automatic final_report;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #100us;
    n_mismatch++;
    final_report;
  end
  initial begin
    {rst_n, drive_enable, ping_start, position_valid, position_pair, loop_update} = '0;
    position_coil = '0;
    target_current_ma = '0;
    amp_ma = 16'h0190;
    repeat (4) @(negedge clock);
    chk("coil_enable", 8'h01, coil_enable);
    chk("phase", 15'h3A98, phase_cdeg);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      position_coil = rows[i].c;
      position_pair = rows[i].p;
      pulse(position_valid);
      chk("coil_enable", rows[i].m, coil_enable);
      chk("parallel", rows[i].p && rows[i].c != 3'h7, parallel_switch);
    end
    drive_enable = 1'b1;
    pulse(ping_start);
    chk("state", PSCAP_PING, ctrl_state);
    @(negedge clock);
    chk("legs", 2'b11, {leg_a, leg_b});
    // 150 degrees of an 870 cycle period: leg b falls 362 cycles after leg a rises
    for (n_cyc = 0; n_cyc < 900 && leg_b === 1'b1; n_cyc++) @(negedge clock);
    chk("leg_b_delay", 16'h016A, n_cyc[15:0]);
    // one drive period, so a 400 mA sample lands
    repeat (900) @(negedge clock);
    upd(16'h01F4, 16'h3A34);
    upd(16'h1518, 16'h3264);
    for (int k = 0; k < 7; k++) begin
      upd(16'h0960, (ph > 16'h07D0) ? ph - 16'h07D0 : 16'h0000);
    end
    amp_ma = 16'h1388;
    repeat (900) @(negedge clock);
    chk("limit", 1'b0, current_limit_active);
    amp_ma = 16'h1770;
    for (int k = 0; k < 1000 && current_limit_active !== 1'b1; k++) @(negedge clock);
    chk("limit", 1'b1, current_limit_active);
    chk("phase", 16'h0064, phase_cdeg);
    upd(16'h1F40, 16'h0064);
    drive_enable = 1'b0;
    @(negedge clock);
    chk("state", PSCAP_IDLE, ctrl_state);
    @(negedge clock);
    chk("legs", 2'b00, {leg_a, leg_b});
    // reset while idle drops the pair back to the single default coil
    rst_n = 1'b0;
    @(negedge clock);
    chk("coil_enable", 8'h01, coil_enable);
    chk("parallel", 1'b0, parallel_switch);
    chk("phase", 15'h3A98, phase_cdeg);
    rst_n = 1'b1;
    // 4500 mA trips the single-coil cap but would pass the pair cap
    amp_ma = 16'h1194;
    drive_enable = 1'b1;
    pulse(ping_start);
    for (n_cyc = 0; n_cyc < 1000 && current_limit_active !== 1'b1; n_cyc++) @(negedge clock);
    chk("limit", 1'b1, current_limit_active);
    chk("phase", 16'h3AFC, phase_cdeg);
    final_report;
  end
endmodule

//--- testbench/pscap_ctrl_properties.sv
`timescale 1ns/1ps
// ****************************************
// port properties
// ****************************************
module pscap_ctrl_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic drive_enable,
  input wire logic ping_start,
  input wire logic position_valid,
  input wire pscap_pkg::pscap_coil_t position_coil,
  input wire logic current_valid,
  input wire pscap_pkg::pscap_ma_t cell_current_ma,
  input wire pscap_pkg::pscap_mask_t coil_enable,
  input wire logic parallel_switch,
  input wire logic leg_a,
  input wire pscap_pkg::pscap_cdeg_t phase_cdeg,
  input wire logic current_limit_active,
  input wire pscap_pkg::pscap_state_e ctrl_state
);
  import pscap_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_ping_take;
    drive_enable && ping_start;
  endsequence
  sequence s_ping_entry;
    ctrl_state == PSCAP_PING && phase_cdeg == 15'h3A98;
  endsequence
  chk_coil_count: assert property ($countones(coil_enable) inside {1, 2})
    else $error("coil count");
  chk_switch_match: assert property (parallel_switch == ($countones(coil_enable) == 2))
    else $error("switch state");
  chk_pair_adjacent: assert property (parallel_switch |-> (coil_enable & (coil_enable >> 1)) != 8'h00)
    else $error("pair not adjacent");
  chk_position_take: assert property (position_valid && ctrl_state == PSCAP_IDLE |=> coil_enable[$past(position_coil)])
    else $error("coil not taken");
  chk_ping_entry: assert property (s_ping_take |=> s_ping_entry)
    else $error("ping entry");
  chk_phase_range: assert property (phase_cdeg <= 15'h4650)
    else $error("phase range");
  chk_drive_half: assert property ($fell(leg_a) && ctrl_state != PSCAP_IDLE |-> $past(leg_a, 435) && !$past(leg_a, 436))
    else $error("half period");
  chk_limit_flag: assert property (current_valid && drive_enable && !ping_start && ctrl_state != PSCAP_IDLE |=>
    current_limit_active == ($past(cell_current_ma) > (parallel_switch ? 16'h1618 : 16'h1092)))
    else $error("limit flag");
endmodule
bind pscap_ctrl pscap_ctrl_checker chk_u (.clock, .rst_n, .drive_enable, .ping_start, .position_valid,
  .position_coil, .current_valid, .cell_current_ma, .coil_enable, .parallel_switch, .leg_a,
  .phase_cdeg, .current_limit_active, .ctrl_state);

//--- testbench/pscap_sense.sv
`timescale 1ns/1ps
// ****************************************
// cell current sense, one sample per period
// ****************************************
module pscap_sense (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic leg_a,
  input wire pscap_pkg::pscap_ma_t amp_ma,
  output logic current_valid,
  output pscap_pkg::pscap_ma_t cell_current_ma
);
  import pscap_pkg::*;
  logic leg_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      leg_q <= 1'b0;
      current_valid <= 1'b0;
      cell_current_ma <= '0;
    end else begin
      leg_q <= leg_a;
      current_valid <= leg_a && !leg_q;
      // value not held outside the strobe
      cell_current_ma <= (leg_a && !leg_q) ? amp_ma : ~cell_current_ma;
    end
  end
endmodule
